// ### hdl/cmp_consts.svh
/*
 Constants for the comparator control block: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from hdl/.
*/
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_OFS_CON0      12'h000
`define CMP_OFS_CON1      12'h004
`define CMP_OFS_STAT      12'h008
`define CMP_OFS_MASK      12'h00C
`define CMP_OFS_PORT      12'h010
`define CMP_OFS_PINCFG    12'h014

`define CMP_B_ON          7
`define CMP_B_OUT         6
`define CMP_B_OE          5
`define CMP_B_POL         4
`define CMP_B_SP          2
`define CMP_B_HYS         1
`define CMP_B_SYNC        0
`define CMP_CON0_WMASK    8'hB7
`define CMP_CON0_RESET    8'h04

`define CMP_B_PCH_LO      4
`define CMP_B_NCH_LO      0
`define CMP_CON1_RESET    8'h00
`define CMP_CH_W          2

`define CMP_EV_EDGE       0
`define CMP_EV_POL        1
`define CMP_EV_ON         2
`define CMP_EV_W          3

`define CMP_RESP_NS       1000
`define CMP_CLK_MHZ       200
`define CMP_NS_PER_US     1000
`define CMP_MAX_PINS      32

`define CMP_HTRANS_NONSEQ 2'h2
`define CMP_HSIZE_WORD    3'h2

`endif

// ### hdl/cmp_ctrl.sv
/*
 Digital control of one analog comparator, reached over AHB-Lite.
 Holds the input selectors, enable gating, polarity, output pin
 enable, PWM shutdown/restart sources, interrupt status and the
 port read-back masking for analog pins.
 Assumes the analog result arrives asynchronously and that the
 AHB master issues single word transfers only.
*/
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_ctrl
#(
    parameter int PINS      = 8,
    parameter int RESP_NS   = `CMP_RESP_NS
)
(
    input  wire logic            clock,
    input  wire logic            resetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [11:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // Analog front end
    input  wire logic            compareRaw,
    output logic      [3:0]      posSwitch,
    output logic      [3:0]      negSwitch,
    output logic                 speedPowerSelect,
    output logic                 hysteresisEnable,
    output logic                 timerSyncEnable,
    // Result and pins
    output logic                 resultValid,
    output logic                 resultPinOut,
    output logic                 resultPinOe,
    input  wire logic [PINS-1:0] portPinsIn,
    input  wire logic [PINS-1:0] analogSelect,
    input  wire logic            resultPinDirInput,
    // PWM shutdown
    input  wire logic            autoShutdownActive,
    input  wire logic            autoRestartEnable,
    output logic                 pwmShutdownReq,
    output logic                 pwmRestartReq,
    // Interrupt
    output logic                 irq
);
    import cmp_pkg::*;

    // Rounded up so a slow clock never shortens the response interval
    localparam int RESP_CYC_RAW = (RESP_NS * `CMP_CLK_MHZ
                                  + `CMP_NS_PER_US - 1) / `CMP_NS_PER_US;
    localparam int RESP_CYC     = (RESP_CYC_RAW < 1) ? 1 : RESP_CYC_RAW;

    initial
    begin
        if (PINS < 1 || PINS > `CMP_MAX_PINS)
            $error("PINS must be 1 to 32");
        if (RESP_NS < 1)
            $error("RESP_NS must be at least 1");
    end

    function automatic logic [3:0] onehot4(input logic [1:0] sel);
        onehot4 = 4'h1 << sel;
    endfunction

    // Shared offset decode for the write strobes
    function automatic logic isReg(input logic [11:0] a,
                                   input logic [11:0] ofs);
        isReg = (a == ofs);
    endfunction

    // AHB address phase capture
    logic        wrPend_ff;
    logic        rdPend_ff;
    logic [11:0] addr_ff;
    logic        take;

    assign take = hsel && hready && (htrans == `CMP_HTRANS_NONSEQ);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            addr_ff   <= 12'h000;
        end
        else
        begin
            wrPend_ff <= take && hwrite;
            rdPend_ff <= take && !hwrite;
            if (take)
                addr_ff <= haddr;
        end
    end

    // Zero wait states: every register answers in its first data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wrCon0;
    logic wrCon1;
    logic wrStat;
    logic wrMask;
    assign wrCon0 = wrPend_ff && isReg(addr_ff, `CMP_OFS_CON0);
    assign wrCon1 = wrPend_ff && isReg(addr_ff, `CMP_OFS_CON1);
    assign wrStat = wrPend_ff && isReg(addr_ff, `CMP_OFS_STAT);
    assign wrMask = wrPend_ff && isReg(addr_ff, `CMP_OFS_MASK);

    // Control registers
    logic [7:0] con0_ff;
    logic [7:0] con1_ff;
    logic [7:0] nxt_con0;
    logic [7:0] nxt_con1;

    assign nxt_con0 = hwdata[7:0] & `CMP_CON0_WMASK;

    // Only the two channel fields are kept; the rest reads back 0
    always_comb
    begin
        nxt_con1 = 8'h00;
        nxt_con1[`CMP_B_PCH_LO +: `CMP_CH_W] =
            hwdata[`CMP_B_PCH_LO +: `CMP_CH_W];
        nxt_con1[`CMP_B_NCH_LO +: `CMP_CH_W] =
            hwdata[`CMP_B_NCH_LO +: `CMP_CH_W];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            con0_ff <= `CMP_CON0_RESET;
        else if (wrCon0)
            con0_ff <= nxt_con0;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            con1_ff <= `CMP_CON1_RESET;
        else if (wrCon1)
            con1_ff <= nxt_con1;
    end

    logic        compEnable;
    logic        outPolarity;
    logic        outPinEnable;
    logic [1:0]  negChannel;
    cmp_pch_type posChannel;

    assign compEnable   = con0_ff[`CMP_B_ON];
    assign outPolarity  = con0_ff[`CMP_B_POL];
    assign outPinEnable = con0_ff[`CMP_B_OE];
    assign posChannel   = cmp_pch_type'(con1_ff[`CMP_B_PCH_LO +: `CMP_CH_W]);
    assign negChannel   = con1_ff[`CMP_B_NCH_LO +: `CMP_CH_W];

    assign speedPowerSelect = con0_ff[`CMP_B_SP];
    assign hysteresisEnable = con0_ff[`CMP_B_HYS];
    assign timerSyncEnable  = con0_ff[`CMP_B_SYNC];

    // Input switches: one-hot over pin, DAC, reference, ground
    assign posSwitch = compEnable ? onehot4(posChannel) : 4'h0;
    assign negSwitch = compEnable ? onehot4(negChannel) : 4'h0;

    // Raw result is asynchronous; two flops before use
    logic rawSync;
    logic pinDirSync;
    logic [PINS-1:0] portSync;

    cmp_sync2 #(.W(PINS + 2)) u_sync
    (
        .clock  (clock),
        .resetn (resetn),
        .din    ({compareRaw, resultPinDirInput, portPinsIn}),
        .dout   ({rawSync, pinDirSync, portSync})
    );

    // Polarity applied after sync; disabled comparator reads as the polarity bit
    logic result_ff;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            result_ff <= 1'b0;
        else
            result_ff <= (compEnable & rawSync) ^ outPolarity;
    end

    // Settling timer restarts on any selector or enable change
    cmp_status_if settle ();
    logic selChange;
    // Polarity alone swaps the output, not the inputs, so no restart
    assign selChange = (wrCon1 && (nxt_con1 != con1_ff))
                    || (wrCon0 && nxt_con0[`CMP_B_ON] != compEnable);
    assign settle.restart = selChange;

    cmp_settle_timer #(.RESP_CYCLES(RESP_CYC)) u_settle
    (
        .clock  (clock),
        .resetn (resetn),
        .link   (settle)
    );

    assign resultValid = settle.valid;

    // Output pin works regardless of enable
    assign resultPinOut = result_ff;
    assign resultPinOe  = outPinEnable && !pinDirSync;

    // PWM shutdown sources; gated by validity to avoid glitching the PWM
    assign pwmShutdownReq = autoShutdownActive && resultValid
                          && result_ff;
    assign pwmRestartReq  = autoShutdownActive && autoRestartEnable
                          && resultValid && !result_ff;

    // Events: result edge, polarity toggle, enable toggle
    // Previous value resets to the disabled result, so no edge at reset
    logic resultPrev_ff;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            resultPrev_ff <= 1'b0;
        else
            resultPrev_ff <= result_ff;
    end

    logic [`CMP_EV_W-1:0] events;
    assign events[`CMP_EV_EDGE] = result_ff ^ resultPrev_ff;
    assign events[`CMP_EV_POL]  = wrCon0
        && (nxt_con0[`CMP_B_POL] != outPolarity);
    assign events[`CMP_EV_ON]   = wrCon0
        && (nxt_con0[`CMP_B_ON] != compEnable);

    logic [`CMP_EV_W-1:0] stat_ff;
    logic [`CMP_EV_W-1:0] mask_ff;
    logic [`CMP_EV_W-1:0] clr;
    assign clr = wrStat ? hwdata[`CMP_EV_W-1:0] : '0;

    // Set beats write-one-to-clear in the same cycle
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            stat_ff <= '0;
        else
            stat_ff <= (stat_ff & ~clr) | events;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            mask_ff <= '0;
        else if (wrMask)
            mask_ff <= hwdata[`CMP_EV_W-1:0];
    end

    assign irq = |(stat_ff & mask_ff);

    // Read data
    logic [PINS-1:0] portRead;
    // Analog pins read 0 so a floating digital buffer never shows through
    genvar p;
    generate
        for (p = 0; p < PINS; p++)
        begin : g_portMask
            assign portRead[p] = portSync[p] && !analogSelect[p];
        end
    endgenerate

    logic [7:0] con0Read;
    always_comb
    begin
        con0Read = con0_ff;
        con0Read[`CMP_B_OUT] = result_ff;
    end

    logic [31:0] nxt_hrdata;
    always_comb
    begin
        nxt_hrdata = 32'h0000_0000;
        case (haddr)
            `CMP_OFS_CON0:   nxt_hrdata = {24'h000000, con0Read};
            `CMP_OFS_CON1:   nxt_hrdata = {24'h000000, con1_ff};
            `CMP_OFS_STAT:   nxt_hrdata = 32'(stat_ff);
            `CMP_OFS_MASK:   nxt_hrdata = 32'(mask_ff);
            `CMP_OFS_PORT:   nxt_hrdata = 32'(portRead);
            `CMP_OFS_PINCFG: nxt_hrdata = 32'(analogSelect);
            default:         nxt_hrdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase, valid in data phase
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= nxt_hrdata;
    end
endmodule // cmp_ctrl

// ### hdl/cmp_pkg.sv
/*
 Types shared by the comparator control block.
 Assumes cmp_consts.svh is available for the numeric constants.
*/
package cmp_pkg;

    typedef enum logic [1:0]
    {
        CMP_PCH_PIN  = 2'b00,
        CMP_PCH_DAC  = 2'b01,
        CMP_PCH_FVR  = 2'b10,
        CMP_PCH_GND  = 2'b11
    } cmp_pch_type;

    typedef enum logic [1:0]
    {
        CMP_SETTLED  = 2'b00,
        CMP_SETTLING = 2'b01
    } cmp_settle_type;

endpackage

// ### hdl/cmp_settle_timer.sv
/*
 Response-interval timer: result is held invalid for a fixed count of
 cycles after any input or reference change.
 Assumes restart is a same-clock pulse from the control core.
*/
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_settle_timer
#(
    parameter int RESP_CYCLES = 200
)
(
    input  wire logic   clock,
    input  wire logic   resetn,
    cmp_status_if.timer link
);
    import cmp_pkg::*;

    localparam int CW = $clog2(RESP_CYCLES + 1);

    initial
    begin
        if (RESP_CYCLES < 1)
            $error("RESP_CYCLES must be at least 1");
    end

    cmp_settle_type  state_ff;
    logic [CW-1:0]   count_ff;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= CMP_SETTLING;
            count_ff <= '0;
        end
        else if (link.restart)
        begin
            state_ff <= CMP_SETTLING;
            count_ff <= '0;
        end
        else
        begin
            case (state_ff)
                CMP_SETTLING:
                begin
                    if (count_ff == CW'(RESP_CYCLES - 1))
                        state_ff <= CMP_SETTLED;
                    else
                        count_ff <= count_ff + 1'b1;
                end
                CMP_SETTLED:
                    state_ff <= CMP_SETTLED;
                default:
                    state_ff <= CMP_SETTLING;
            endcase
        end
    end

    // Restart pulse masks validity at once, not one cycle late
    assign link.valid = (state_ff == CMP_SETTLED) && !link.restart;
endmodule // cmp_settle_timer

// ### hdl/cmp_status_if.sv
/*
 Carrier between the control core and its settling timer.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface cmp_status_if;
    logic restart;
    logic valid;

    modport core  (output restart, input  valid);
    modport timer (input  restart, output valid);
endinterface : cmp_status_if

// ### hdl/cmp_sync2.sv
/*
 Two-flop synchroniser for a vector of asynchronous levels.
 Assumes inputs are quasi-static levels (comparator result, pins).
*/
`timescale 1ns/1ps
module cmp_sync2
#(
    parameter int W = 1
)
(
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    initial
    begin
        if (W < 1)
            $error("W must be at least 1");
    end

    logic [W-1:0] meta_ff;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= '0;
            dout    <= '0;
        end
        else
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule // cmp_sync2

// ### testbench/cmp_ctrl_sva.sv
/*
 Assertion checker for the comparator control top ports.
 Assumes one clock, async active-low reset, RESP_NS above 35.
*/
`timescale 1ns/1ps
module cmp_ctrl_sva
#(
    parameter int RESP_NS = 1000
)
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic [3:0] posSwitch,
    input wire logic [3:0] negSwitch,
    input wire logic       resultValid,
    input wire logic       resultPinOe,
    input wire logic       resultPinDirInput,
    input wire logic       autoShutdownActive,
    input wire logic       autoRestartEnable,
    input wire logic       pwmShutdownReq,
    input wire logic       pwmRestartReq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Direction must settle through the pin synchroniser first
    sequence s_dirHeld;
        resultPinDirInput [*3];
    endsequence

    sequence s_lowHeld;
        !resultValid [*8];
    endsequence

    AST_POS_ONEHOT: assert property ($onehot0(posSwitch))
        else $error("Positive selector not one-hot");
    AST_NEG_ONEHOT: assert property ($onehot0(negSwitch))
        else $error("Negative selector not one-hot");
    AST_GATE_BOTH: assert property ((posSwitch == 4'h0) == (negSwitch == 4'h0))
        else $error("Input switches not gated together");
    AST_VALID_DROP: assert property (!$stable(posSwitch) || !$stable(negSwitch)
        |-> ##[0:2] !resultValid)
        else $error("Result still valid after input change");
    AST_VALID_HOLD: assert property ($fell(resultValid) |-> s_lowHeld)
        else $error("Response interval too short");
    AST_RESET_VALID: assert property ($rose(resetn) |-> s_lowHeld)
        else $error("Result valid too soon after reset");
    AST_SD_GATE: assert property (pwmShutdownReq
        |-> autoShutdownActive && resultValid)
        else $error("Shutdown request without active shutdown");
    AST_RS_GATE: assert property (pwmRestartReq |-> autoShutdownActive
        && autoRestartEnable && resultValid && !pwmShutdownReq)
        else $error("Restart request not qualified");
    AST_PIN_DIR: assert property (s_dirHeld |=> !resultPinOe)
        else $error("Result pin driven while direction is input");
endmodule // cmp_ctrl_sva

bind cmp_ctrl cmp_ctrl_sva #(.RESP_NS(RESP_NS)) u_cmp_ctrl_sva
(
    .clock(clock),
    .resetn(resetn),
    .posSwitch(posSwitch),
    .negSwitch(negSwitch),
    .resultValid(resultValid),
    .resultPinOe(resultPinOe),
    .resultPinDirInput(resultPinDirInput),
    .autoShutdownActive(autoShutdownActive),
    .autoRestartEnable(autoRestartEnable),
    .pwmShutdownReq(pwmShutdownReq),
    .pwmRestartReq(pwmRestartReq)
);

// ### testbench/tb_top.sv
/*
 Self-checking testbench for cmp_ctrl over AHB-Lite.
 Assumes the hdl files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "cmp_consts.svh"
module tb_top;
    import cmp_pkg::*;
    logic        clock, resetn, hsel, hwrite, hready, raw;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic        hreadyout, hresp, valid, spd, hys, syn;
    logic [3:0]  posSw, negSw;
    logic        pinOut, pinOe, dirIn, sdAct, rsEn, sdReq, rsReq, irq;
    logic [7:0]  pinsIn, anaSel;
    int          err_count = 0;
    int          num_checks = 0;

    assign hready = hreadyout;

    // Short response interval keeps the run brief: 50 ns is 10 cycles
    cmp_ctrl #(.PINS(8), .RESP_NS(50)) u_cmp_ctrl
    (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .compareRaw(raw),
        .posSwitch(posSw), .negSwitch(negSw), .speedPowerSelect(spd),
        .hysteresisEnable(hys), .timerSyncEnable(syn),
        .resultValid(valid), .resultPinOut(pinOut),
        .resultPinOe(pinOe), .portPinsIn(pinsIn), .analogSelect(anaSel),
        .resultPinDirInput(dirIn), .autoShutdownActive(sdAct),
        .autoRestartEnable(rsEn), .pwmShutdownReq(sdReq),
        .pwmRestartReq(rsReq), .irq(irq)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits n edges, then lets that edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= `CMP_HTRANS_NONSEQ;
        hsize <= `CMP_HSIZE_WORD;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        rv = hrdata;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        {resetn, hsel, hwrite, raw, sdAct, rsEn} = 6'h00;
        {haddr, htrans, hsize, hwdata} = 49'h0;
        dirIn = 1'b1;
        pinsIn = 8'hFF;
        anaSel = 8'hF0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        cyc(1);
        chk(valid, 1'b0);
        rd(`CMP_OFS_CON0, 32'h04);
        rd(`CMP_OFS_CON1, 32'h00);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, `CMP_OFS_CON1, (k << `CMP_B_PCH_LO) | k);
            chk(posSw, 32'h0);
            bus(1'b1, `CMP_OFS_CON0, 32'h84);
            chk(posSw, 32'h1 << k);
            chk(negSw, 32'h1 << k);
            bus(1'b1, `CMP_OFS_CON0, 32'h04);
        end
        bus(1'b1, `CMP_OFS_CON0, 32'h87);
        chk({spd, hys, syn}, 32'h7);
        cyc(12);
        chk(valid, 1'b1);
        bus(1'b1, `CMP_OFS_CON1, 32'h01);
        cyc(2);
        chk(valid, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            raw <= i[0];
            bus(1'b1, `CMP_OFS_CON0, 32'h84 | (i[1] << 4));
            cyc(14);
            rd(`CMP_OFS_CON0, 32'h84 | (i[1] << 4) | ((i[0] ^ i[1]) << 6));
        end
        sdAct <= 1'b1;
        rsEn <= 1'b1;
        cyc(2);
        chk({sdReq, rsReq}, 32'h1);
        bus(1'b1, `CMP_OFS_CON0, 32'h84);
        cyc(4);
        chk({sdReq, rsReq}, 32'h2);
        sdAct <= 1'b0;
        raw <= 1'b0;
        bus(1'b1, `CMP_OFS_CON0, 32'h24);
        dirIn <= 1'b0;
        cyc(4);
        chk(pinOe, 1'b1);
        chk(pinOut, 1'b0);
        dirIn <= 1'b1;
        cyc(4);
        chk(pinOe, 1'b0);
        bus(1'b1, `CMP_OFS_STAT, 32'h7);
        bus(1'b1, `CMP_OFS_MASK, 32'h4);
        bus(1'b1, `CMP_OFS_CON0, 32'h34);
        cyc(4);
        chk(pinOut, 1'b1);
        rd(`CMP_OFS_STAT, 32'h3);
        chk(irq, 1'b0);
        bus(1'b1, `CMP_OFS_CON0, 32'h94);
        cyc(14);
        rd(`CMP_OFS_STAT, 32'h7);
        chk(irq, 1'b1);
        bus(1'b1, `CMP_OFS_STAT, 32'h7);
        rd(`CMP_OFS_STAT, 32'h0);
        chk(irq, 1'b0);
        rd(`CMP_OFS_PORT, 32'h0F);
        rd(`CMP_OFS_PINCFG, 32'hF0);
        bus(1'b1, 12'h020, 32'hFF);
        rd(12'h020, 32'h0);
        chk({hreadyout, hresp}, 32'h2);
        tally_and_finish();
    end
endmodule // tb_top
